// *** verilog/fdl_pkg.sv ***
package fdl_pkg;
	// -------------------------------------------------------------
	// link control codes
	// -------------------------------------------------------------
	localparam logic [7:0] FDL_DLE = 8'h10;
	localparam logic [7:0] FDL_STX = 8'h02;
	localparam logic [7:0] FDL_ETX = 8'h03;
	localparam logic [7:0] FDL_ACK = 8'h06;
	localparam logic [7:0] FDL_NAK = 8'h15;
	localparam logic [7:0] FDL_ENQ = 8'h05;
	// -------------------------------------------------------------
	// message limits and header bytes for duplicate detection
	// -------------------------------------------------------------
	localparam logic [7:0] FDL_MIN_LEN = 8'h06;
	localparam logic [7:0] FDL_MAX_LEN = 8'hfa;
	localparam int FDL_BUF_D = 250;
	localparam int FDL_HB0 = 1;
	localparam int FDL_HB1 = 2;
	localparam int FDL_HB2 = 4;
	localparam int FDL_HB3 = 5;
	// -------------------------------------------------------------
	// widths, option fields, reset values
	// -------------------------------------------------------------
	localparam int FDL_TW = 16;
	localparam int FDL_CW = 4;
	localparam int FDL_FIFO_W = 9;
	localparam int FDL_FIFO_D = 16;
	localparam int FDL_OPT_DUP = 0;
	localparam int FDL_OPT_ADDR = 1;
	localparam logic FDL_LAST_RST = 1'b0;
endpackage

// *** verilog/fdl_link.sv ***
`timescale 1ns/1ps

// -------------------------------------------------------------
// message source buffer
// -------------------------------------------------------------
module fdl_fifo #(
	parameter int W = 9,
	parameter int D = 16
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [W-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [W-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_q, rp_q;
	logic [AW:0] cnt_q, cnt_d;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	assign out_valid = cnt_q != '0;
	assign out_data = mem[rp_q];
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wp_q] <= in_data;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			in_ready <= 1'b0;
		end else begin
			wp_q <= wp_q + AW'(push);
			rp_q <= rp_q + AW'(pop);
			cnt_q <= cnt_d;
			in_ready <= cnt_d != (AW+1)'(D);
		end
	end
endmodule

// Contract
// - idle with offered message: send packet, wait
// - acknowledge reply: report success, next message
// - negative reply: count, resend; over cap fails
// - timeout: send enquiry, count, restart timer
// - enquiry count over cap: report failure
// - both retry counters cleared per message
// - other reply codes ignored while waiting
// - packet: start, data with check, end, check
// - last reply kept, resets negative, resent on enquiry
// - idle drops all but start/enquiry; marks negative
// - start resets check sum and buffer
// - store data; past full drop, keep summing
// - serial errors during assembly latch error flag
// - stray control code aborts, negative reply
// - end checks error, sum, length, address
// - duplicate header: discard, still acknowledge
// - duplicate test off when option cleared
// - sink full negative; else forward, save, acknowledge
// - every sent reply stored as last reply
// - check byte is negated byte sum of data
// - escape data byte doubled, counted once
// - length must be 6 to 250 bytes
// - header is message bytes 2,3,5,6
module fdl_link
	import fdl_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [7:0] src_data,
	input wire logic src_last,
	input wire logic src_valid,
	output logic src_ready,
	output logic src_done,
	output logic src_ok,
	output logic [7:0] tx_byte,
	output logic tx_valid,
	input wire logic tx_ready,
	input wire logic rep_valid,
	input wire logic [7:0] rep_code,
	input wire logic [FDL_TW-1:0] cfg_timeout,
	input wire logic [FDL_CW-1:0] cfg_nak_cap,
	input wire logic [FDL_CW-1:0] enquiry_retry_cap,
	input wire logic [1:0] option_switch_group,
	input wire logic [7:0] cfg_addr,
	input wire logic [7:0] rx_byte,
	input wire logic rx_valid,
	input wire logic rx_err,
	output logic rx_ready,
	output logic [7:0] rsp_byte,
	output logic rsp_valid,
	input wire logic rsp_ready,
	input wire logic sink_full,
	output logic [7:0] sink_data,
	output logic sink_valid,
	output logic sink_last
);
	typedef enum logic [3:0] {
		T_IDLE, T_LOAD, T_SOH, T_STX, T_DATA, T_DDLE, T_EDLE,
		T_ETX, T_CKB, T_WAIT, T_QDLE, T_QENQ
	} fdl_tx_st_t;
	typedef enum logic [2:0] {R_IDLE, R_BUILD, R_CKB, R_CHECK, R_FWD} fdl_rx_st_t;
	typedef enum logic [1:0] {RS_IDLE, RS_ESC, RS_CODE} fdl_rs_t;

	// -------------------------------------------------------------
	// transmitter
	// -------------------------------------------------------------
	fdl_tx_st_t t_st_q;
	logic [7:0] tbuf [FDL_BUF_D];
	logic [7:0] tlen_q, idx_q, tsum_q;
	logic [FDL_TW-1:0] tmr_q, tmo_q;
	logic [FDL_CW-1:0] nak_q, enq_q, nakcap_q, enqcap_q;
	logic [FDL_FIFO_W-1:0] fo_data;
	logic fo_valid, t_emit;
	logic [7:0] t_byte;

	wire fo_ready = t_st_q == T_LOAD;
	wire free = !tx_valid || tx_ready;
	wire [7:0] t_cur = tbuf[idx_q];
	wire rep_ack = rep_valid && rep_code == FDL_ACK;
	wire rep_nak = rep_valid && rep_code == FDL_NAK;

	fdl_fifo #(.W(FDL_FIFO_W), .D(FDL_FIFO_D)) u_fifo (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.in_data({src_last, src_data}),
		.in_valid(src_valid),
		.in_ready(src_ready),
		.out_data(fo_data),
		.out_valid(fo_valid),
		.out_ready(fo_ready)
	);

	always_comb begin
		t_emit = 1'b1;
		t_byte = FDL_DLE;
		unique case (t_st_q)
			T_STX: t_byte = FDL_STX;
			T_DATA: begin
				t_emit = idx_q != tlen_q;
				t_byte = t_cur;
			end
			T_ETX: t_byte = FDL_ETX;
			T_CKB: t_byte = 8'h00 - tsum_q;
			T_QENQ: t_byte = FDL_ENQ;
			T_SOH, T_DDLE, T_EDLE, T_QDLE: t_emit = 1'b1;
			T_IDLE, T_LOAD, T_WAIT: t_emit = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (t_st_q == T_LOAD && fo_valid && tlen_q < FDL_MAX_LEN) begin
			tbuf[tlen_q] <= fo_data[7:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			tx_valid <= 1'b0;
			tx_byte <= 8'h00;
		end else if (free) begin
			tx_valid <= t_emit;
			tx_byte <= t_byte;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			t_st_q <= T_IDLE;
			tlen_q <= 8'h00;
			idx_q <= 8'h00;
			tsum_q <= 8'h00;
			tmr_q <= '0;
			tmo_q <= '0;
			nak_q <= '0;
			enq_q <= '0;
			nakcap_q <= '0;
			enqcap_q <= '0;
			src_done <= 1'b0;
			src_ok <= 1'b0;
		end else begin
			src_done <= 1'b0;
			unique case (t_st_q)
				T_IDLE: if (fo_valid) begin
					tmo_q <= cfg_timeout;
					nakcap_q <= cfg_nak_cap;
					enqcap_q <= enquiry_retry_cap;
					nak_q <= '0;
					enq_q <= '0;
					tlen_q <= 8'h00;
					t_st_q <= T_LOAD;
				end
				T_LOAD: if (fo_valid) begin
					if (tlen_q < FDL_MAX_LEN) begin
						tlen_q <= tlen_q + 8'h01;
					end
					if (fo_data[8]) begin
						t_st_q <= T_SOH;
					end
				end
				T_SOH: if (free) begin
					t_st_q <= T_STX;
				end
				T_STX: if (free) begin
					tsum_q <= 8'h00;
					idx_q <= 8'h00;
					t_st_q <= T_DATA;
				end
				T_DATA: if (free) begin
					if (idx_q == tlen_q) begin
						t_st_q <= T_EDLE;
					end else begin
						tsum_q <= tsum_q + t_cur;
						if (t_cur == FDL_DLE) begin
							t_st_q <= T_DDLE;
						end else begin
							idx_q <= idx_q + 8'h01;
						end
					end
				end
				T_DDLE: if (free) begin
					idx_q <= idx_q + 8'h01;
					t_st_q <= T_DATA;
				end
				T_EDLE: if (free) begin
					t_st_q <= T_ETX;
				end
				T_ETX: if (free) begin
					t_st_q <= T_CKB;
				end
				T_CKB, T_QENQ: if (free) begin
					tmr_q <= tmo_q;
					t_st_q <= T_WAIT;
				end
				T_QDLE: if (free) begin
					t_st_q <= T_QENQ;
				end
				T_WAIT: begin
					if (rep_ack) begin
						src_done <= 1'b1;
						src_ok <= 1'b1;
						t_st_q <= T_IDLE;
					end else if (rep_nak) begin
						if (nak_q >= nakcap_q) begin
							src_done <= 1'b1;
							src_ok <= 1'b0;
							t_st_q <= T_IDLE;
						end else begin
							nak_q <= nak_q + 1'b1;
							t_st_q <= T_SOH;
						end
					end else if (tmr_q == '0) begin
						if (enq_q >= enqcap_q) begin
							src_done <= 1'b1;
							src_ok <= 1'b0;
							t_st_q <= T_IDLE;
						end else begin
							enq_q <= enq_q + 1'b1;
							t_st_q <= T_QDLE;
						end
					end else begin
						tmr_q <= tmr_q - 1'b1;
					end
				end
			endcase
		end
	end

	// -------------------------------------------------------------
	// receiver
	// -------------------------------------------------------------
	fdl_rx_st_t r_st_q;
	fdl_rs_t rs_q;
	logic [7:0] rbuf [FDL_BUF_D];
	logic [7:0] rlen_q, sum_q, fidx_q;
	logic [31:0] hdr_q;
	logic hdr_ok_q, esc_q, err_q, ckb_ok_q, last_ack_q;
	logic rq_go, rq_ack;

	wire take = rx_valid && rx_ready;
	wire is_dle = rx_byte == FDL_DLE;
	wire dat = take && (esc_q ? is_dle : !is_dle);
	wire ctl = take && esc_q && !is_dle;
	wire [31:0] hdr_now = {rbuf[FDL_HB0], rbuf[FDL_HB1], rbuf[FDL_HB2], rbuf[FDL_HB3]};
	wire len_ok = rlen_q >= FDL_MIN_LEN && rlen_q <= FDL_MAX_LEN;
	wire addr_ok = !option_switch_group[FDL_OPT_ADDR] || rbuf[0] == cfg_addr;
	wire msg_ok = !err_q && ckb_ok_q && len_ok && addr_ok;
	wire dup = option_switch_group[FDL_OPT_DUP] && hdr_ok_q && hdr_q == hdr_now;
	wire idle_enq = r_st_q == R_IDLE && ctl && rx_byte == FDL_ENQ;
	wire build_abort = r_st_q == R_BUILD && ctl && rx_byte != FDL_ETX;
	wire chk = r_st_q == R_CHECK;
	wire fwd_go = chk && msg_ok && !dup && !sink_full;

	assign rq_go = idle_enq || build_abort || chk;
	assign rq_ack = idle_enq ? last_ack_q : (chk && msg_ok && (dup || !sink_full));

	always_ff @(posedge ref_clk) begin
		if (r_st_q == R_BUILD && dat && rlen_q < FDL_MAX_LEN) begin
			rbuf[rlen_q] <= rx_byte;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			rs_q <= RS_IDLE;
			rsp_valid <= 1'b0;
			rsp_byte <= 8'h00;
			last_ack_q <= FDL_LAST_RST;
		end else begin
			unique case (rs_q)
				RS_IDLE: if (rq_go) begin
					last_ack_q <= rq_ack;
					rsp_byte <= FDL_DLE;
					rsp_valid <= 1'b1;
					rs_q <= RS_ESC;
				end else if (r_st_q == R_IDLE && take && !(esc_q && rx_byte == FDL_STX) && !(!esc_q && is_dle)) begin
					last_ack_q <= 1'b0;
				end
				RS_ESC: if (rsp_ready) begin
					rsp_byte <= last_ack_q ? FDL_ACK : FDL_NAK;
					rs_q <= RS_CODE;
				end
				RS_CODE: if (rsp_ready) begin
					rsp_valid <= 1'b0;
					rs_q <= RS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			r_st_q <= R_IDLE;
			rx_ready <= 1'b0;
			esc_q <= 1'b0;
			err_q <= 1'b0;
			ckb_ok_q <= 1'b0;
			rlen_q <= 8'h00;
			sum_q <= 8'h00;
			fidx_q <= 8'h00;
			hdr_q <= '0;
			hdr_ok_q <= 1'b0;
			sink_valid <= 1'b0;
			sink_last <= 1'b0;
			sink_data <= 8'h00;
		end else begin
			rx_ready <= (r_st_q == R_IDLE || r_st_q == R_BUILD || r_st_q == R_CKB)
				&& rs_q == RS_IDLE && !take && !rq_go;
			sink_valid <= 1'b0;
			sink_last <= 1'b0;
			if (take) begin
				esc_q <= !esc_q && is_dle && r_st_q != R_CKB;
			end
			unique case (r_st_q)
				R_IDLE: if (ctl && rx_byte == FDL_STX) begin
					sum_q <= 8'h00;
					rlen_q <= 8'h00;
					err_q <= 1'b0;
					r_st_q <= R_BUILD;
				end
				R_BUILD: begin
					if (take && rx_err) begin
						err_q <= 1'b1;
					end
					if (dat) begin
						sum_q <= sum_q + rx_byte;
						if (rlen_q != 8'hff) begin
							rlen_q <= rlen_q + 8'h01;
						end
					end else if (ctl) begin
						r_st_q <= rx_byte == FDL_ETX ? R_CKB : R_IDLE;
					end
				end
				R_CKB: if (take) begin
					ckb_ok_q <= 8'(sum_q + rx_byte) == 8'h00;
					r_st_q <= R_CHECK;
				end
				R_CHECK: begin
					fidx_q <= 8'h00;
					if (fwd_go) begin
						hdr_q <= hdr_now;
						hdr_ok_q <= 1'b1;
					end
					r_st_q <= fwd_go ? R_FWD : R_IDLE;
				end
				R_FWD: begin
					sink_valid <= 1'b1;
					sink_data <= rbuf[fidx_q];
					sink_last <= fidx_q == rlen_q - 8'h01;
					fidx_q <= fidx_q + 8'h01;
					if (fidx_q == rlen_q - 8'h01) begin
						r_st_q <= R_IDLE;
					end
				end
			endcase
		end
	end

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
		else $error("tx byte changed while stalled");
	chk_ack_done: assert property (t_st_q == T_WAIT && rep_ack |=> src_done && src_ok)
		else $error("ack did not report success");
	chk_nak_cap: assert property (t_st_q == T_WAIT && rep_nak && nak_q >= nakcap_q |=> src_done && !src_ok)
		else $error("nak over cap did not fail");
	chk_nak_resend: assert property (t_st_q == T_WAIT && rep_nak && nak_q < nakcap_q
		|=> t_st_q == T_SOH && nak_q == $past(nak_q) + 1'b1)
		else $error("nak did not resend");
	chk_enq_send: assert property (t_st_q == T_WAIT && !rep_valid && tmr_q == '0 && enq_q < enqcap_q
		|=> t_st_q == T_QDLE && enq_q == $past(enq_q) + 1'b1)
		else $error("timeout did not send enquiry");
	chk_enq_code: assert property (t_st_q == T_QENQ && free |=> tx_valid && tx_byte == FDL_ENQ)
		else $error("enquiry code not sent");
	chk_enq_cap: assert property (t_st_q == T_WAIT && !rep_valid && tmr_q == '0 && enq_q >= enqcap_q
		|=> src_done && !src_ok && t_st_q == T_IDLE)
		else $error("enquiry cap did not fail");
	chk_cnt_clear: assert property (t_st_q == T_IDLE && fo_valid |=> nak_q == '0 && enq_q == '0)
		else $error("retry counters not cleared");
	chk_other_code: assert property (t_st_q == T_WAIT && rep_valid && !rep_ack && !rep_nak && tmr_q != '0
		|=> t_st_q == T_WAIT && !src_done)
		else $error("stray reply code acted on");
	chk_rsp_code: assert property (rsp_valid && rs_q == RS_ESC && rsp_ready
		|=> rsp_valid && rsp_byte == (last_ack_q ? FDL_ACK : FDL_NAK))
		else $error("reply code differs from stored reply");
	chk_abort_nak: assert property (build_abort && rs_q == RS_IDLE |=> r_st_q == R_IDLE && !last_ack_q)
		else $error("abort did not nak");
	chk_sink_full: assert property (chk && msg_ok && !dup && sink_full |=> r_st_q == R_IDLE && !last_ack_q)
		else $error("message forwarded to full sink");
	chk_dup_ack: assert property (chk && msg_ok && dup |=> r_st_q == R_IDLE && last_ack_q)
		else $error("duplicate not acknowledged");

	cov_ack: cover property (t_st_q == T_WAIT && rep_ack);
	cov_enq: cover property (t_st_q == T_QENQ);
	cov_fwd: cover property (sink_last);
	cov_dup: cover property (chk && msg_ok && dup);
endmodule

// *** verification/fdl_remote_model.sv ***
`timescale 1ns/1ps

// -------------------------------------------------------------
// far station: receives our packets, answers, drains replies
// -------------------------------------------------------------
module fdl_remote_model
	import fdl_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [7:0] tx_byte,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic rep_valid,
	output logic [7:0] rep_code,
	input wire logic [7:0] rep_mode,
	output int frames,
	output int enqs,
	output int dlen,
	output logic sum_ok,
	input wire logic [7:0] rsp_byte,
	input wire logic rsp_valid,
	output logic rsp_ready,
	output logic [7:0] last_rsp,
	output int rsp_n
);
	logic esc_q, ckb_q, rsp_esc_q;
	logic [7:0] sum_q;
	logic [1:0] pace_q;
	// stalls one cycle in three on each path
	assign tx_ready = pace_q != 2'h2;
	assign rsp_ready = pace_q != 2'h0;
	always_ff @(posedge ref_clk) begin
		rep_valid <= 1'b0;
		rep_code <= ~rep_code;
		if (!nrst) begin
			{esc_q, ckb_q, rsp_esc_q, sum_ok} <= 4'h0;
			{sum_q, last_rsp, rep_code} <= 24'h000000;
			pace_q <= 2'h0;
			frames <= 0;
			enqs <= 0;
			dlen <= 0;
			rsp_n <= 0;
		end else begin
			pace_q <= (pace_q == 2'h2) ? 2'h0 : pace_q + 2'h1;
			if (tx_valid && tx_ready) begin
				if (esc_q) begin
					esc_q <= 1'b0;
					if (tx_byte == FDL_DLE) begin
						sum_q <= sum_q + tx_byte;
						dlen <= dlen + 1;
					end else if (tx_byte == FDL_STX) begin
						sum_q <= 8'h00;
						dlen <= 0;
					end else if (tx_byte == FDL_ETX) begin
						ckb_q <= 1'b1;
					end else if (tx_byte == FDL_ENQ) begin
						enqs <= enqs + 1;
						rep_valid <= rep_mode != 8'h00;
						rep_code <= rep_mode;
					end
				end else if (ckb_q) begin
					ckb_q <= 1'b0;
					frames <= frames + 1;
					sum_ok <= (sum_q + tx_byte) == 8'h00;
					rep_valid <= rep_mode != 8'h00;
					rep_code <= rep_mode;
				end else if (tx_byte == FDL_DLE) begin
					esc_q <= 1'b1;
				end else begin
					sum_q <= sum_q + tx_byte;
					dlen <= dlen + 1;
				end
			end
			if (rsp_valid && rsp_ready) begin
				rsp_esc_q <= rsp_byte == FDL_DLE && !rsp_esc_q;
				if (rsp_esc_q) begin
					last_rsp <= rsp_byte;
					rsp_n <= rsp_n + 1;
				end
			end
		end
	end
endmodule

// *** verification/test_full_duplex_link_protocol.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
	$display("ERROR %0t: got %h expected %h", $time, got, exp); end end

module test_full_duplex_link_protocol;
	import fdl_pkg::*;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] src_data = 8'h00, rx_byte = 8'h00, rep_mode = 8'h06, cfg_addr = 8'h21, last_rsp, tx_byte;
	logic [7:0] rsp_byte, sink_data, rep_code;
	logic src_last = 1'b0, src_valid = 1'b0, rx_valid = 1'b0, rx_err = 1'b0, sink_full = 1'b0;
	logic src_ready, src_done, src_ok, tx_valid, tx_ready, rep_valid, rx_ready, rsp_valid, rsp_ready;
	logic sink_valid, sink_last, sum_ok;
	logic [15:0] cfg_timeout = 16'h0014;
	logic [3:0] cfg_nak_cap = 4'h2, enq_cap = 4'h2;
	logic [1:0] opt = 2'h3;
	int err_count = 0, n_compared = 0, frames, enqs, dlen, rsp_n, rn, last_at;
	logic [7:0] sink_q [$];
	logic [7:0] msg [6] = '{8'h21, 8'h10, 8'h03, 8'h04, 8'h05, 8'h06};

	always #4 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (sink_valid === 1'b1) begin
			sink_q.push_back(sink_data);
			if (sink_last === 1'b1) last_at = sink_q.size();
		end
	end

	fdl_link fdl_link_i(.ref_clk(ref_clk), .nrst(nrst), .src_data(src_data), .src_last(src_last),
		.src_valid(src_valid), .src_ready(src_ready), .src_done(src_done), .src_ok(src_ok),
		.tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .rep_valid(rep_valid),
		.rep_code(rep_code), .cfg_timeout(cfg_timeout), .cfg_nak_cap(cfg_nak_cap),
		.enquiry_retry_cap(enq_cap), .option_switch_group(opt), .cfg_addr(cfg_addr),
		.rx_byte(rx_byte), .rx_valid(rx_valid), .rx_err(rx_err), .rx_ready(rx_ready),
		.rsp_byte(rsp_byte), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .sink_full(sink_full),
		.sink_data(sink_data), .sink_valid(sink_valid), .sink_last(sink_last));
	fdl_remote_model fdl_remote_model_i(.ref_clk(ref_clk), .nrst(nrst), .tx_byte(tx_byte),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .rep_valid(rep_valid), .rep_code(rep_code),
		.rep_mode(rep_mode), .frames(frames), .enqs(enqs), .dlen(dlen), .sum_ok(sum_ok),
		.rsp_byte(rsp_byte), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .last_rsp(last_rsp),
		.rsp_n(rsp_n));

	// -------------------------------------------------------------
	// access tasks
	// -------------------------------------------------------------
	task stop_test;
		$display("compared %0d, errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task hang;
		err_count++;
		$display("ERROR %0t: wait timed out", $time);
		stop_test;
	endtask

	task tx_case(input logic [7:0] mode, input logic ok, input int df, input int de);
		int i, k, f0, e0;
		rep_mode <= mode;
		f0 = frames;
		e0 = enqs;
		for (k = 0; k < 6; k++) begin
			src_data <= msg[k];
			src_last <= k == 5;
			src_valid <= 1'b1;
			i = 0;
			do begin @(posedge ref_clk); i++; end while (src_ready !== 1'b1 && i < 100);
			if (src_ready !== 1'b1) hang;
		end
		src_valid <= 1'b0;
		i = 0;
		do begin @(posedge ref_clk); i++; end while (src_done !== 1'b1 && i < 3000);
		if (src_done !== 1'b1) hang;
		`CHK(src_ok, ok)
		`CHK(frames - f0, df)
		`CHK(enqs - e0, de)
		`CHK(dlen, 6)
		`CHK(sum_ok, 1'b1)
	endtask

	task rx_put(input logic [7:0] b, input logic e);
		int i;
		rx_byte <= b;
		rx_err <= e;
		rx_valid <= 1'b1;
		i = 0;
		do begin @(posedge ref_clk); i++; end while (rx_ready !== 1'b1 && i < 100);
		if (rx_ready !== 1'b1) hang;
	endtask

	task rx_reply(input logic [7:0] exp);
		int i;
		rx_valid <= 1'b0;
		rx_err <= 1'b0;
		rx_byte <= ~rx_byte;
		i = 0;
		do begin @(posedge ref_clk); i++; end while (rsp_n == rn && i < 100);
		if (rsp_n == rn) hang;
		`CHK(last_rsp, exp)
		repeat (10) @(posedge ref_clk);
	endtask

	task rx_enq(input logic [7:0] exp);
		rn = rsp_n;
		rx_put(FDL_DLE, 1'b0);
		rx_put(FDL_ENQ, 1'b0);
		rx_reply(exp);
	endtask

	task rx_case(input int len, input logic [7:0] badd, input int err_at, input logic [7:0] exp, input int fwd);
		int k;
		logic [7:0] s;
		s = 8'h00;
		rn = rsp_n;
		sink_q.delete();
		last_at = 0;
		rx_put(FDL_DLE, 1'b0);
		rx_put(FDL_STX, 1'b0);
		for (k = 0; k < len; k++) begin
			s = s + msg[k % 6];
			if (msg[k % 6] == FDL_DLE) rx_put(FDL_DLE, 1'b0);
			rx_put(msg[k % 6], k == err_at);
		end
		rx_put(FDL_DLE, 1'b0);
		rx_put(FDL_ETX, 1'b0);
		rx_put(8'h00 - s + badd, 1'b0);
		rx_reply(exp);
		`CHK(sink_q.size(), fwd * len)
		`CHK(last_at, fwd * len)
		for (k = 0; k < sink_q.size() && fwd == 1; k++) `CHK(sink_q[k], msg[k % 6])
	endtask

	// -------------------------------------------------------------
	// main sequence
	// -------------------------------------------------------------
	initial begin
		repeat (6) @(posedge ref_clk);
		`CHK(src_ready, 1'b0)
		`CHK(rx_ready, 1'b0)
		nrst <= 1'b1;
		rx_enq(FDL_NAK);
		tx_case(FDL_ACK, 1'b1, 1, 0);
		tx_case(FDL_NAK, 1'b0, 3, 0);
		tx_case(FDL_NAK, 1'b0, 3, 0);
		tx_case(8'h07, 1'b0, 1, 2);
		cfg_nak_cap <= 4'h1;
		tx_case(FDL_NAK, 1'b0, 2, 0);
		rx_case(6, 8'h00, -1, FDL_ACK, 1);
		rx_enq(FDL_ACK);
		rx_case(6, 8'h00, -1, FDL_ACK, 0);
		opt <= 2'h2;
		rx_case(6, 8'h00, -1, FDL_ACK, 1);
		opt <= 2'h3;
		rx_case(6, 8'h01, -1, FDL_NAK, 0);
		rx_enq(FDL_NAK);
		rx_case(6, 8'h00, 3, FDL_NAK, 0);
		rx_case(5, 8'h00, -1, FDL_NAK, 0);
		rx_case(251, 8'h00, -1, FDL_NAK, 0);
		cfg_addr <= 8'h22;
		rx_case(6, 8'h00, -1, FDL_NAK, 0);
		cfg_addr <= 8'h21;
		msg[2] = 8'h33;
		sink_full <= 1'b1;
		rx_case(6, 8'h00, -1, FDL_NAK, 0);
		sink_full <= 1'b0;
		rn = rsp_n;
		rx_put(FDL_DLE, 1'b0);
		rx_put(FDL_STX, 1'b0);
		rx_put(8'h01, 1'b0);
		rx_put(FDL_DLE, 1'b0);
		rx_put(FDL_ACK, 1'b0);
		rx_reply(FDL_NAK);
		rx_case(6, 8'h00, -1, FDL_ACK, 1);
		rx_put(8'h41, 1'b0);
		rx_enq(FDL_NAK);
		stop_test;
	end
endmodule
